// *** shared/iss_map.svh ***
`ifndef ISS_MAP_SVH
`define ISS_MAP_SVH

`define ISS_RX_DATA_ADDR 32'hFFFF0930
`define ISS_TX_DATA_ADDR 32'hFFFF0934
`define ISS_STATUS_ADDR 32'hFFFF0928
`define ISS_FIFO_STA_ADDR 32'hFFFF094C

`define ISS_BUSY_BIT 6
`define ISS_NACK_BIT 5
`define ISS_OVF_BIT 4
`define ISS_RXREQ_BIT 3
`define ISS_TXREQ_BIT 2
`define ISS_UF_BIT 1
`define ISS_EARLY_BIT 0
`define ISS_FLUSH_TX_BIT 8

`define ISS_DATA_RESET 8'h00
`define ISS_TX_IDLE_BYTE 8'hFF
`define ISS_FIFO_DEPTH 32
`define ISS_NUM_EV 9
`define ISS_SYNC_STAGES 2

`endif

// *** shared/iss_pkg.sv ***
package iss_pkg;

    typedef enum logic [3:0] {
        EV_START = 4'h0,
        EV_STOP = 4'h1,
        EV_NOMATCH = 4'h2,
        EV_RD_RISE = 4'h3,
        EV_WR_RISE = 4'h4,
        EV_RD_FALL = 4'h5,
        EV_NACK = 4'h6,
        EV_RXB = 4'h7,
        EV_TXREQ = 4'h8
    } iss_ev_t;

    typedef enum logic [2:0] {
        L_IDLE = 3'h0,
        L_ADDR = 3'h1,
        L_AACK = 3'h2,
        L_RX = 3'h3,
        L_RACK = 3'h4,
        L_TXW = 3'h5,
        L_TX = 3'h6,
        L_TACK = 3'h7
    } iss_link_state_t;

endpackage

// *** rtl/iss_fifo.sv ***
`timescale 1ns/100ps
module iss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic full_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q, rd_ptr_q;
    logic [AW:0] count_q;
    logic push, pop;

    assign full_out = (count_q == (AW+1)'(DEPTH));
    assign in_ready_out = ~full_out;
    assign out_valid_out = (count_q != '0);
    assign out_data_out = mem_q[rd_ptr_q];
    assign push = in_valid_in & in_ready_out & ~flush_in;
    assign pop = out_valid_out & out_ready_in & ~flush_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else if (flush_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    AST_FLUSH_EMPTIES: assert property (@(posedge clk_in) disable iff (rst_in) // [R15]
        flush_in |=> !out_valid_out)
        else $error("fifo not empty after flush");
    AST_NO_PUSH_FULL: assert property (@(posedge clk_in) disable iff (rst_in)
        full_out && !pop && !flush_in |=> full_out)
        else $error("full fifo lost its fill");
endmodule // iss_fifo

// *** rtl/iss_slave.sv ***
// How it works
// [R01] busy flag set on start condition
// [R02] busy cleared on mismatch, stop, restart mismatch
// [R03] nack flag on empty-fifo or forced nack
// [R04] overflow flag on push into full fifo
// [R05] receive request while receive fifo non-empty
// [R06] receive request interrupt when enabled
// [R07] transmit request on matching read address
// [R08] transmit request edge follows early enable
// [R09] transmit request interrupt when enabled
// [R10] underflow at read bit if fifo empty
// [R11] early flag: empty fifo, or write bit
// [R12] early flag once per transfer, read clears
// [R13] receive data register, read only, 0x00
// [R14] transmit data register, write only, 0x00
// [R15] flush bit empties transmit fifo
// [R16] status writes never change hardware flags
`timescale 1ns/100ps
`include "iss_map.svh"
module iss_slave
    import iss_pkg::*;
#(
    parameter int DEPTH = `ISS_FIFO_DEPTH
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [6:0] own_addr_in,
    input wire logic force_nack_enable_in,
    input wire logic early_tx_enable_in,
    input wire logic rx_request_irq_enable_in,
    input wire logic tx_request_irq_enable_in,
    input wire logic [31:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic irq_out
);
    function automatic logic [1:0] fifo_code(input logic valid, input logic full);
        fifo_code = !valid ? 2'h0 : (full ? 2'h3 : 2'h2);
    endfunction

    // ---------------- link domain ----------------
    logic [1:0] link_rst_q;
    logic link_rst;
    logic [2:0] scl_s_q, sda_s_q;
    logic [1:0] force_s_q, empty_s_q, txack_s_q;
    iss_link_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, rx_hold_q;
    logic rd_q, match_q, mack_q, sda_oe_q;
    logic [`ISS_NUM_EV-1:0] ev_tgl_q;
    logic scl_rise, scl_fall, start_det, stop_det, sda_v, addr_hit;
    logic txack_tgl_q, tx_empty, stretch_q;
    logic [7:0] tx_byte_q;

    // hold the link logic in reset until the release is seen on its own clock
    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_rst_q <= 2'h3;
        end else begin
            link_rst_q <= {link_rst_q[0], 1'b0};
        end
    end
    assign link_rst = link_rst_q[1];

    // pins and sys-side levels pass two flops; edges use stages 1 and 2 only
    always_ff @(posedge link_clk_in or posedge link_rst) begin
        if (link_rst) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            force_s_q <= 2'h0;
            empty_s_q <= 2'h0;
            txack_s_q <= 2'h0;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
            force_s_q <= {force_s_q[0], force_nack_enable_in};
            empty_s_q <= {empty_s_q[0], tx_empty};
            txack_s_q <= {txack_s_q[0], txack_tgl_q};
        end
    end

    assign sda_v = sda_s_q[1];
    assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
    assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
    assign start_det = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
    assign stop_det = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
    assign addr_hit = (sh_q[6:0] == own_addr_in);

    // every bus event flips its own toggle so none is lost across the crossing
    always_ff @(posedge link_clk_in or posedge link_rst) begin
        if (link_rst) begin
            state_q <= L_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            rx_hold_q <= `ISS_DATA_RESET;
            rd_q <= 1'b0;
            match_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            ev_tgl_q <= '0;
        end else if (start_det) begin
            state_q <= L_ADDR;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            ev_tgl_q[EV_START] <= ~ev_tgl_q[EV_START]; // [R01]
        end else if (stop_det) begin
            state_q <= L_IDLE;
            sda_oe_q <= 1'b0;
            ev_tgl_q[EV_STOP] <= ~ev_tgl_q[EV_STOP]; // [R02]
        end else begin
            unique case (state_q)
                L_IDLE: begin
                end
                L_ADDR: begin
                    if (scl_rise && cnt_q == 4'h7) begin
                        rd_q <= sda_v;
                        match_q <= addr_hit;
                        cnt_q <= 4'h8;
                        if (!addr_hit) begin
                            ev_tgl_q[EV_NOMATCH] <= ~ev_tgl_q[EV_NOMATCH]; // [R02]
                        end else if (sda_v) begin
                            ev_tgl_q[EV_RD_RISE] <= ~ev_tgl_q[EV_RD_RISE]; // [R07]
                        end else begin
                            ev_tgl_q[EV_WR_RISE] <= ~ev_tgl_q[EV_WR_RISE]; // [R11]
                        end
                    end else if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_v};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        if (!match_q) begin
                            state_q <= L_IDLE;
                        end else begin
                            if (rd_q) begin
                                ev_tgl_q[EV_RD_FALL] <= ~ev_tgl_q[EV_RD_FALL]; // [R08]
                            end
                            if (force_s_q[1] || (rd_q && empty_s_q[1])) begin
                                ev_tgl_q[EV_NACK] <= ~ev_tgl_q[EV_NACK]; // [R03]
                                state_q <= L_IDLE;
                            end else begin
                                sda_oe_q <= 1'b1;
                                state_q <= L_AACK;
                            end
                        end
                    end
                end
                L_AACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                        if (rd_q) begin
                            ev_tgl_q[EV_TXREQ] <= ~ev_tgl_q[EV_TXREQ];
                            state_q <= L_TXW;
                        end else begin
                            state_q <= L_RX;
                        end
                    end
                end
                L_RX: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_v};
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h7) begin
                            rx_hold_q <= {sh_q[6:0], sda_v};
                            ev_tgl_q[EV_RXB] <= ~ev_tgl_q[EV_RXB];
                        end
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        sda_oe_q <= 1'b1;
                        state_q <= L_RACK;
                    end
                end
                L_RACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                        state_q <= L_RX;
                    end
                end
                L_TXW: begin
                    // scl is stretched here until the system side answers
                    if (txack_s_q[1] == ev_tgl_q[EV_TXREQ]) begin
                        sh_q <= tx_byte_q;
                        sda_oe_q <= ~tx_byte_q[7];
                        cnt_q <= 4'h0;
                        state_q <= L_TX;
                    end
                end
                L_TX: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        sda_oe_q <= 1'b0;
                        state_q <= L_TACK;
                    end else if (scl_fall) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        sda_oe_q <= ~sh_q[6];
                    end
                end
                L_TACK: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_v;
                    end else if (scl_fall && mack_q) begin
                        ev_tgl_q[EV_TXREQ] <= ~ev_tgl_q[EV_TXREQ];
                        state_q <= L_TXW;
                    end else if (scl_fall) begin
                        state_q <= L_IDLE;
                    end
                end
            endcase
        end
    end

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    // scl is let go one cycle after the first data bit is on sda, so that bit gets setup time
    always_ff @(posedge link_clk_in or posedge link_rst) begin
        if (link_rst) begin
            stretch_q <= 1'b0;
        end else begin
            stretch_q <= (state_q == L_TXW);
        end
    end
    assign scl_oe_out = stretch_q;
    assign sda_oe_out = sda_oe_q;

    AST_ACK_AFTER_WRITE_BYTE: assert property (@(posedge link_clk_in) disable iff (link_rst)
        state_q == L_RX && scl_fall && cnt_q == 4'h8 && !start_det && !stop_det |=> sda_oe_out)
        else $error("no ack driven after received byte");

    // ---------------- system domain ----------------
    logic [`ISS_NUM_EV-1:0] ev_s0_q, ev_s1_q, ev_s2_q, ev;
    logic tx_valid, tx_full, tx_push, tx_pop, tx_flush;
    logic [7:0] tx_data;
    logic rx_valid, rx_full, rx_in_ready, rx_pop;
    logic [7:0] rx_data;
    logic busy_q, nack_q, ovf_q, txreq_q, uf_q, early_q, armed_q, irq_q;
    logic [15:0] rdata_q;
    logic hit_status, hit_rx, hit_tx, hit_fsta, status_rd, early_set;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ev_s0_q <= '0;
            ev_s1_q <= '0;
            ev_s2_q <= '0;
        end else begin
            ev_s0_q <= ev_tgl_q;
            ev_s1_q <= ev_s0_q;
            ev_s2_q <= ev_s1_q;
        end
    end
    assign ev = ev_s1_q ^ ev_s2_q;

    assign hit_status = (reg_addr_in == `ISS_STATUS_ADDR);
    assign hit_rx = (reg_addr_in == `ISS_RX_DATA_ADDR);
    assign hit_tx = (reg_addr_in == `ISS_TX_DATA_ADDR);
    assign hit_fsta = (reg_addr_in == `ISS_FIFO_STA_ADDR);
    assign status_rd = reg_rd_in & hit_status;
    // status writes have no decode at all
    assign tx_push = reg_wr_in & hit_tx; // [R14] [R16]
    assign tx_flush = reg_wr_in & hit_fsta & reg_wdata_in[`ISS_FLUSH_TX_BIT]; // [R15]
    assign rx_pop = reg_rd_in & hit_rx; // [R13]
    assign tx_pop = ev[EV_TXREQ];
    assign tx_empty = ~tx_valid;

    iss_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .flush_in(tx_flush),
        .in_valid_in(tx_push),
        .in_ready_out(),
        .in_data_in(reg_wdata_in[7:0]),
        .out_valid_out(tx_valid),
        .out_ready_in(tx_pop),
        .out_data_out(tx_data),
        .full_out(tx_full)
    );

    iss_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .flush_in(1'b0),
        .in_valid_in(ev[EV_RXB]),
        .in_ready_out(rx_in_ready),
        .in_data_in(rx_hold_q),
        .out_valid_out(rx_valid),
        .out_ready_in(rx_pop),
        .out_data_out(rx_data),
        .full_out(rx_full)
    );

    // tx byte stays put until the next request, so the link may read it freely
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_byte_q <= `ISS_DATA_RESET;
            txack_tgl_q <= 1'b0;
        end else if (ev[EV_TXREQ]) begin
            tx_byte_q <= tx_valid ? tx_data : `ISS_TX_IDLE_BYTE;
            txack_tgl_q <= ~txack_tgl_q;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
        end else if (ev[EV_START]) begin
            busy_q <= 1'b1; // [R01]
        end else if (ev[EV_STOP] || ev[EV_NOMATCH]) begin
            busy_q <= 1'b0; // [R02]
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            nack_q <= 1'b0;
        end else if (ev[EV_NACK]) begin
            nack_q <= 1'b1; // [R03]
        end else if (ev[EV_START]) begin
            nack_q <= 1'b0;
        end
    end

    // a dropped byte is the only back-pressure the bus side can take
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ovf_q <= 1'b0;
        end else if (ev[EV_RXB] && !rx_in_ready) begin
            ovf_q <= 1'b1; // [R04]
        end else if (ev[EV_RXB] || ev[EV_START]) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            txreq_q <= 1'b0;
        end else if (early_tx_enable_in ? ev[EV_RD_RISE] : ev[EV_RD_FALL]) begin
            txreq_q <= 1'b1; // [R07] [R08]
        end else if (tx_push || ev[EV_STOP] || ev[EV_START]) begin
            txreq_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            uf_q <= 1'b0;
        end else if (ev[EV_RD_RISE] && tx_empty) begin
            uf_q <= 1'b1; // [R10]
        end else if (tx_push || ev[EV_START]) begin
            uf_q <= 1'b0;
        end
    end

    assign early_set = armed_q & (early_tx_enable_in ? ev[EV_WR_RISE] : (busy_q & tx_empty)); // [R11]

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            armed_q <= 1'b0;
        end else if (ev[EV_START]) begin
            armed_q <= 1'b1;
        end else if (early_set) begin
            armed_q <= 1'b0; // [R12]
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            early_q <= 1'b0;
        end else if (early_set) begin
            early_q <= 1'b1; // [R11]
        end else if (status_rd) begin
            early_q <= 1'b0; // [R12]
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (rx_valid & rx_request_irq_enable_in) | (txreq_q & tx_request_irq_enable_in); // [R06] [R09]
        end
    end
    assign irq_out = irq_q;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd_in) begin
            rdata_q <= 16'h0000;
            if (hit_status) begin
                rdata_q[`ISS_BUSY_BIT] <= busy_q;
                rdata_q[`ISS_NACK_BIT] <= nack_q;
                rdata_q[`ISS_OVF_BIT] <= ovf_q;
                rdata_q[`ISS_RXREQ_BIT] <= rx_valid; // [R05]
                rdata_q[`ISS_TXREQ_BIT] <= txreq_q;
                rdata_q[`ISS_UF_BIT] <= uf_q;
                rdata_q[`ISS_EARLY_BIT] <= early_q;
            end else if (hit_rx) begin
                rdata_q[7:0] <= rx_valid ? rx_data : `ISS_DATA_RESET; // [R13]
            end else if (hit_fsta) begin
                rdata_q[3:0] <= {fifo_code(rx_valid, rx_full), fifo_code(tx_valid, tx_full)};
            end
        end
    end
    assign reg_rdata_out = rdata_q;

    AST_BUSY_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R01]
        ev[EV_START] |=> busy_q)
        else $error("busy not set by start");
    AST_BUSY_CLR: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R02]
        (ev[EV_STOP] || ev[EV_NOMATCH]) && !ev[EV_START] |=> !busy_q)
        else $error("busy not cleared");
    AST_NACK_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R03]
        ev[EV_NACK] |=> nack_q)
        else $error("nack flag missing");
    AST_OVF_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R04]
        ev[EV_RXB] && rx_full |=> ovf_q)
        else $error("overflow flag missing");
    AST_RXREQ_READ: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R05]
        status_rd |=> reg_rdata_out[`ISS_RXREQ_BIT] == $past(rx_valid))
        else $error("receive request does not track fifo");
    AST_RX_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R06]
        rx_valid && rx_request_irq_enable_in |=> irq_out)
        else $error("receive interrupt missing");
    AST_TXREQ_EDGE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R08]
        early_tx_enable_in && ev[EV_RD_RISE] |=> txreq_q)
        else $error("transmit request late");
    AST_TX_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R09]
        txreq_q && tx_request_irq_enable_in |=> irq_out)
        else $error("transmit interrupt missing");
    AST_UF_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R10]
        ev[EV_RD_RISE] && tx_empty |=> uf_q)
        else $error("underflow flag missing");
    AST_EARLY_CLR: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R12]
        status_rd && !early_set |=> !early_q)
        else $error("early flag survived read");
    AST_EARLY_ONCE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R12]
        early_set ##1 !ev[EV_START] [*2] |-> !early_set)
        else $error("early flag set twice");
endmodule // iss_slave

// *** test/iss_master.sv ***
`timescale 1ns/100ps
module iss_master #(
    parameter int HALF = 500
) (
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out,
    output logic stuck_out
);
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
        stuck_out = 1'b0;
    end
    // waits out clock stretching, but never forever
    task automatic rise();
        int n;
        n = 0;
        scl_low_out = 1'b0;
        while (scl_in !== 1'b1 && n < 4000) begin
            #10;
            n++;
        end
        if (n >= 4000) stuck_out = 1'b1;
    endtask
    task automatic bit_io(input logic b, output logic seen);
        scl_low_out = 1'b1;
        #(HALF/2);
        sda_low_out = ~b;
        #(HALF/2);
        rise();
        #(HALF/2);
        seen = sda_in;
        #(HALF/2);
        scl_low_out = 1'b1;
    endtask
    task automatic start();
        sda_low_out = 1'b0;
        #(HALF/2);
        rise();
        #HALF;
        sda_low_out = 1'b1;
        #HALF;
        scl_low_out = 1'b1;
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        #HALF;
        rise();
        #HALF;
        sda_low_out = 1'b0;
        #HALF;
    endtask
    // msb first, ninth bit is the acknowledge slot
    task automatic byte_io(input logic [7:0] o, input logic a, output logic [7:0] i, output logic ak);
        for (int k = 7; k >= 0; k--) bit_io(o[k], i[k]);
        bit_io(a, ak);
    endtask
endmodule // iss_master

// *** test/iss_slave_bench.sv ***
`timescale 1ns/100ps
`include "iss_map.svh"
module iss_slave_bench;
    logic ref_clk_in = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic rd_s = 1'b0, wr_s = 1'b0, fnack = 1'b0, early = 1'b0, rxie = 1'b0, txie = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [15:0] wdata = 16'h0, rdata;
    logic scl_oe, sda_oe, m_scl, m_sda, stuck, irq, scl, sda, ak;
    logic [7:0] b;
    int n_mismatch = 0, compares = 0;
    // open-drain wires with pull-ups
    assign scl = ~(scl_oe | m_scl);
    assign sda = ~(sda_oe | m_sda);
    always #50 ref_clk_in = ~ref_clk_in;
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    iss_slave dut (.ref_clk_in(ref_clk_in), .rst_in(rst), .link_clk_in(link_clk), .scl_in(scl), .scl_out(),
        .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .own_addr_in(7'h2A),
        .force_nack_enable_in(fnack), .early_tx_enable_in(early), .rx_request_irq_enable_in(rxie),
        .tx_request_irq_enable_in(txie), .reg_addr_in(addr), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .irq_out(irq));
    iss_master m (.scl_in(scl), .sda_in(sda), .scl_low_out(m_scl), .sda_low_out(m_sda), .stuck_out(stuck));
    task automatic wrap_up();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(negedge ref_clk_in);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge ref_clk_in);
        wr_s = 1'b0;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [15:0] mask, input logic [15:0] exp);
        @(negedge ref_clk_in);
        addr = a;
        rd_s = 1'b1;
        @(negedge ref_clk_in);
        rd_s = 1'b0;
        @(negedge ref_clk_in);
        check(rdata & mask, exp);
    endtask
    task automatic settle();
        repeat (8) @(negedge ref_clk_in);
    endtask
    always @(posedge stuck) begin
        n_mismatch++;
        wrap_up();
    end
    initial begin
        #5ms;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (2) @(negedge ref_clk_in);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk_in);
        rdc(`ISS_RX_DATA_ADDR, 16'hFFFF, 16'h0000);
        rdc(`ISS_TX_DATA_ADDR, 16'hFFFF, 16'h0000);
        rdc(32'hFFFF0900, 16'hFFFF, 16'h0000);
        wr(`ISS_STATUS_ADDR, 16'hFFFF);
        rdc(`ISS_STATUS_ADDR, 16'hFFFF, 16'h0000);
        // write frame: one byte more than the fifo holds
        rxie = 1'b1;
        m.start();
        m.byte_io(8'h54, 1'b1, b, ak);
        check({15'h0, ak}, 16'h0000);
        rdc(`ISS_STATUS_ADDR, 16'h0041, 16'h0041);
        for (int i = 0; i <= 32; i++) m.byte_io(8'h40 + i[7:0], 1'b1, b, ak);
        m.stop();
        settle();
        rdc(`ISS_STATUS_ADDR, 16'hFFFF, 16'h0018);
        rdc(`ISS_STATUS_ADDR, 16'h0001, 16'h0000);
        check({15'h0, irq}, 16'h0001);
        rdc(`ISS_FIFO_STA_ADDR, 16'h000F, 16'h000C);
        for (int i = 0; i < 32; i++) rdc(`ISS_RX_DATA_ADDR, 16'h00FF, 16'h0040 + i[15:0]);
        rdc(`ISS_STATUS_ADDR, 16'h0008, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        // read with nothing queued
        m.start();
        m.byte_io(8'h55, 1'b1, b, ak);
        check({15'h0, ak}, 16'h0001);
        rdc(`ISS_STATUS_ADDR, 16'h0004, 16'h0004);
        m.stop();
        settle();
        rdc(`ISS_STATUS_ADDR, 16'h007E, 16'h0022);
        // foreign address
        m.start();
        m.byte_io(8'h22, 1'b1, b, ak);
        check({15'h0, ak}, 16'h0001);
        settle();
        rdc(`ISS_STATUS_ADDR, 16'h0040, 16'h0000);
        m.stop();
        // read two queued bytes, early timing selected
        @(negedge ref_clk_in);
        early = 1'b1;
        txie = 1'b1;
        wr(`ISS_TX_DATA_ADDR, 16'h005A);
        wr(`ISS_TX_DATA_ADDR, 16'h00C3);
        m.start();
        m.byte_io(8'h55, 1'b1, b, ak);
        check({15'h0, ak}, 16'h0000);
        rdc(`ISS_STATUS_ADDR, 16'h0006, 16'h0004);
        check({15'h0, irq}, 16'h0001);
        m.byte_io(8'hFF, 1'b0, b, ak);
        check({8'h0, b}, 16'h005A);
        m.byte_io(8'hFF, 1'b1, b, ak);
        check({8'h0, b}, 16'h00C3);
        m.stop();
        settle();
        rdc(`ISS_STATUS_ADDR, 16'h0004, 16'h0000);
        // flush, then forced refusal of a write frame with early timing still selected
        wr(`ISS_TX_DATA_ADDR, 16'h0011);
        rdc(`ISS_FIFO_STA_ADDR, 16'h0003, 16'h0002);
        wr(`ISS_FIFO_STA_ADDR, 16'h0100);
        rdc(`ISS_FIFO_STA_ADDR, 16'h0003, 16'h0000);
        fnack = 1'b1;
        m.start();
        m.byte_io(8'h54, 1'b1, b, ak);
        check({15'h0, ak}, 16'h0001);
        m.stop();
        settle();
        rdc(`ISS_STATUS_ADDR, 16'h0021, 16'h0021);
        wrap_up();
    end
endmodule // iss_slave_bench
